// ==== hdl/sfrc_pkg.sv ====
// Constants, states and carrier types of the serial flash read command engine
package sfrc_pkg;

    // ************************************************************
    // Opcodes
    // ************************************************************
    localparam logic [7:0] SFRC_OP_READ = 8'h03;
    localparam logic [7:0] SFRC_OP_FAST_READ = 8'h0B;
    localparam logic [7:0] SFRC_OP_DUAL_OUTPUT_READ = 8'h3B;
    localparam logic [7:0] SFRC_OP_DUAL_IO_READ = 8'hBB;
    localparam logic [7:0] SFRC_OP_SET_READ_PARAM = 8'hC0;
    localparam logic [7:0] SFRC_OP_MODE_RESET = 8'hFF;

    // ************************************************************
    // Phase lengths in serial clocks
    // ************************************************************
    localparam logic [4:0] SFRC_OPCODE_CLKS = 5'h08;
    localparam logic [4:0] SFRC_ADDR_CLKS_X1 = 5'h18;
    localparam logic [4:0] SFRC_ADDR_CLKS_X2 = 5'h0C;
    localparam logic [4:0] SFRC_MODE_CLKS = 5'h04;
    localparam logic [4:0] SFRC_DUMMY_FAST = 5'h08;
    localparam logic [4:0] SFRC_DUMMY_DUAL_OUTPUT = 5'h08;
    localparam logic [4:0] SFRC_DUMMY_DC0 = 5'h04;
    localparam logic [4:0] SFRC_DUMMY_DC1 = 5'h08;
    localparam logic [4:0] SFRC_DUMMY_P00 = 5'h04;
    localparam logic [4:0] SFRC_DUMMY_P01 = 5'h04;
    localparam logic [4:0] SFRC_DUMMY_P10 = 5'h06;
    localparam logic [4:0] SFRC_DUMMY_P11 = 5'h08;
    localparam logic [4:0] SFRC_NO_DUMMY = 5'h00;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int SFRC_CONT_LSB = 4;
    localparam int SFRC_PARAM_LSB = 4;
    localparam logic [1:0] SFRC_CONT_KEY = 2'h2;
    localparam logic [1:0] SFRC_PARAM_RST = 2'h0;
    localparam logic SFRC_CONT_RST = 1'b0;
    localparam logic [3:0] SFRC_SYNC_RST = 4'h8;

    // ************************************************************
    // Types
    // ************************************************************
    typedef enum logic [2:0] {
        SFRC_ST_OPCODE = 3'b000,
        SFRC_ST_ADDR = 3'b001,
        SFRC_ST_MODE = 3'b010,
        SFRC_ST_DUMMY = 3'b011,
        SFRC_ST_DATA = 3'b100,
        SFRC_ST_PARAM = 3'b101,
        SFRC_ST_IGNORE = 3'b110
    } sfrc_state_e;

    typedef struct packed {
        logic dual_addr;
        logic dual_data;
        logic mode_phase;
        logic [4:0] dummy_clks;
    } sfrc_cmd_s;

endpackage

// ==== hdl/sfrc_array_mem.sv ====
// Flash array storage with registered read data and a preload port
`timescale 1ns/1ps
module sfrc_array_mem
    import sfrc_pkg::*;
#(
    parameter int ADDR_W = 19,
    parameter int DATA_W = 8
) (
    input wire logic i_clk,
    input wire logic i_wr_en,
    input wire logic [ADDR_W-1:0] i_wr_addr,
    input wire logic [DATA_W-1:0] i_wr_data,
    input wire logic [ADDR_W-1:0] i_rd_addr,
    output logic [DATA_W-1:0] o_rd_data
);

    logic [DATA_W-1:0] mem_reg [0:(1<<ADDR_W)-1];

    always_ff @(posedge i_clk) begin
        if (i_wr_en) begin
            mem_reg[i_wr_addr] <= i_wr_data;
        end
    end

    always_ff @(posedge i_clk) begin
        o_rd_data <= mem_reg[i_rd_addr];
    end

endmodule

// ==== hdl/sfrc_read_engine.sv ====
// Serial flash read command engine: decodes and serves single and dual line reads
//
// Notes on behaviour
// - Read 03h: opcode, three address bytes on io_line_0, then data, no dummy.
// - Address sampled on rising serial clock, data changed on falling serial clock.
// - Read address advances by one after every byte shifted out.
// - Address counter wraps from the top of the array to zero.
// - Chip select high at any time ends the read and releases outputs.
// - Fast read 0Bh: opcode, address, one dummy byte outside four-line mode, then one bit per clock.
// - Fast, dual-output and dual-I/O reads are ignored while a write cycle runs.
// - Four-line mode fast read uses 4, 6 or 8 dummy clocks set by C0h.
// - Dual-output read 3Bh: single-line opcode and address, 8 dummies, two-bit data.
// - Dual-output read widens only the data phase.
// - Dual-I/O read BBh: single-line opcode, address two bits per clock.
// - Dual-I/O read carries address, mode bits and data two bits per clock.
// - Dual-I/O dummy phase on both lines, length set by dummy_cycle_select.
// - Dual-I/O dummy count is 4 clocks, or 8 with dummy_cycle_select set.
// - Mode bits follow the address and are captured for continuous mode.
// - Continuous bits equal to (1,0) make the next read start at the address.
// - Any other continuous bits value returns to full opcode decoding.
// - A mode reset command is only decoded outside continuous mode, so it never clears the continuous state.
`timescale 1ns/1ps
module sfrc_read_engine
    import sfrc_pkg::*;
#(
    parameter int ADDR_W = 19
) (
    input wire logic I_CLOCK,
    input wire logic I_RST_B,
    input wire logic I_CS_B,
    input wire logic I_SCLK,
    input wire logic I_IO_LINE_0,
    input wire logic I_IO_LINE_1,
    input wire logic I_WRITE_BUSY,
    input wire logic I_FOUR_LINE_MODE,
    input wire logic I_DUMMY_CYCLE_SELECT,
    input wire logic I_LOAD_EN,
    input wire logic [ADDR_W-1:0] I_LOAD_ADDR,
    input wire logic [7:0] I_LOAD_DATA,
    output logic O_IO_LINE_0,
    output logic O_IO_LINE_0_OE,
    output logic O_IO_LINE_1,
    output logic O_IO_LINE_1_OE,
    output logic O_CONTINUOUS_MODE,
    output logic [1:0] O_READ_PARAM
);

    // ************************************************************
    // Declarations
    // ************************************************************
    logic [3:0] sync1_reg;
    logic [3:0] sync2_reg;
    logic sclk_dly_reg;
    logic cs_b;
    logic sclk;
    logic io0;
    logic io1;
    logic sclk_rise;
    logic sclk_fall;

    sfrc_state_e state_reg;
    sfrc_state_e state_next;
    sfrc_state_e start_state;
    sfrc_state_e dec_state;
    sfrc_cmd_s cmd_reg;
    sfrc_cmd_s cmd_dec;
    sfrc_cmd_s start_cmd;

    logic [4:0] cnt_reg;
    logic [4:0] phase_len;
    logic phase_done;
    logic dual_in;
    logic [23:0] in_sh_reg;
    logic [23:0] in_full;
    logic [4:0] param_dummy;
    logic [4:0] dc_dummy;

    logic [ADDR_W-1:0] addr_reg;
    logic [ADDR_W-1:0] addr_max;
    logic cont_reg;
    logic [1:0] read_param_reg;

    logic [7:0] mem_rdata;
    logic [7:0] out_sh_reg;
    logic [7:0] byte_src;
    logic [2:0] out_cnt_reg;
    logic byte_fetch;
    logic drive_reg;
    logic io0_out_reg;
    logic io1_out_reg;

    // ************************************************************
    // Pin synchronisers and serial clock edges
    // ************************************************************
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            sync1_reg <= SFRC_SYNC_RST;
            sync2_reg <= SFRC_SYNC_RST;
        end else begin
            sync1_reg <= {I_CS_B, I_SCLK, I_IO_LINE_1, I_IO_LINE_0};
            sync2_reg <= sync1_reg;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            sclk_dly_reg <= 1'b0;
        end else begin
            sclk_dly_reg <= sync2_reg[2];
        end
    end

    assign cs_b = sync2_reg[3];
    assign sclk = sync2_reg[2];
    assign io1 = sync2_reg[1];
    assign io0 = sync2_reg[0];
    // Inputs are taken on rising edges, outputs move on falling edges
    assign sclk_rise = sclk & ~sclk_dly_reg & ~cs_b;
    assign sclk_fall = ~sclk & sclk_dly_reg & ~cs_b;

    // ************************************************************
    // Dummy clock selection
    // ************************************************************
    always_comb begin
        case (read_param_reg)
            2'h0: param_dummy = SFRC_DUMMY_P00;
            2'h1: param_dummy = SFRC_DUMMY_P01;
            2'h2: param_dummy = SFRC_DUMMY_P10;
            default: param_dummy = SFRC_DUMMY_P11;
        endcase
    end

    assign dc_dummy = I_DUMMY_CYCLE_SELECT ? SFRC_DUMMY_DC1 : SFRC_DUMMY_DC0;

    // ************************************************************
    // Input shifting
    // ************************************************************
    assign dual_in = cmd_reg.dual_addr && (state_reg == SFRC_ST_ADDR || state_reg == SFRC_ST_MODE);
    assign in_full = dual_in ? {in_sh_reg[21:0], io1, io0} : {in_sh_reg[22:0], io0};

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            in_sh_reg <= 24'h000000;
        end else if (sclk_rise) begin
            in_sh_reg <= in_full;
        end
    end

    // ************************************************************
    // Phase counting
    // ************************************************************
    always_comb begin
        case (state_reg)
            SFRC_ST_OPCODE: phase_len = SFRC_OPCODE_CLKS;
            SFRC_ST_PARAM: phase_len = SFRC_OPCODE_CLKS;
            SFRC_ST_ADDR: phase_len = cmd_reg.dual_addr ? SFRC_ADDR_CLKS_X2 : SFRC_ADDR_CLKS_X1;
            SFRC_ST_MODE: phase_len = SFRC_MODE_CLKS;
            SFRC_ST_DUMMY: phase_len = cmd_reg.dummy_clks;
            default: phase_len = 5'h1F;
        endcase
    end

    assign phase_done = (cnt_reg + 5'h01) == phase_len;

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B || cs_b) begin
            cnt_reg <= 5'h00;
        end else if (sclk_rise) begin
            cnt_reg <= phase_done ? 5'h00 : cnt_reg + 5'h01;
        end
    end

    // ************************************************************
    // Opcode decoding
    // ************************************************************
    always_comb begin
        cmd_dec = '0;
        dec_state = SFRC_ST_IGNORE;
        if (in_full[7:0] == SFRC_OP_READ) begin
            cmd_dec.dummy_clks = SFRC_NO_DUMMY;
            dec_state = SFRC_ST_ADDR;
        end else if (in_full[7:0] == SFRC_OP_FAST_READ) begin
            cmd_dec.dummy_clks = I_FOUR_LINE_MODE ? param_dummy : SFRC_DUMMY_FAST;
            dec_state = I_WRITE_BUSY ? SFRC_ST_IGNORE : SFRC_ST_ADDR;
        end else if (in_full[7:0] == SFRC_OP_DUAL_OUTPUT_READ) begin
            cmd_dec.dual_data = 1'b1;
            cmd_dec.dummy_clks = SFRC_DUMMY_DUAL_OUTPUT;
            dec_state = I_WRITE_BUSY ? SFRC_ST_IGNORE : SFRC_ST_ADDR;
        end else if (in_full[7:0] == SFRC_OP_DUAL_IO_READ) begin
            cmd_dec.dual_addr = 1'b1;
            cmd_dec.dual_data = 1'b1;
            cmd_dec.mode_phase = 1'b1;
            cmd_dec.dummy_clks = dc_dummy;
            dec_state = I_WRITE_BUSY ? SFRC_ST_IGNORE : SFRC_ST_ADDR;
        end else if (in_full[7:0] == SFRC_OP_SET_READ_PARAM) begin
            dec_state = SFRC_ST_PARAM;
        end
    end

    // Continuous mode skips the opcode and goes straight to the dual address, or to ignore while a write cycle runs
    always_comb begin
        start_cmd = '0;
        start_state = SFRC_ST_OPCODE;
        if (cont_reg) begin
            start_cmd.dual_addr = 1'b1;
            start_cmd.dual_data = 1'b1;
            start_cmd.mode_phase = 1'b1;
            start_cmd.dummy_clks = dc_dummy;
            start_state = I_WRITE_BUSY ? SFRC_ST_IGNORE : SFRC_ST_ADDR;
        end
    end

    // ************************************************************
    // Command state machine
    // ************************************************************
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            SFRC_ST_OPCODE: begin
                if (phase_done) begin
                    state_next = dec_state;
                end
            end
            SFRC_ST_ADDR: begin
                if (phase_done) begin
                    if (cmd_reg.mode_phase) begin
                        state_next = SFRC_ST_MODE;
                    end else if (cmd_reg.dummy_clks == SFRC_NO_DUMMY) begin
                        state_next = SFRC_ST_DATA;
                    end else begin
                        state_next = SFRC_ST_DUMMY;
                    end
                end
            end
            SFRC_ST_MODE: begin
                if (phase_done) begin
                    state_next = SFRC_ST_DUMMY;
                end
            end
            SFRC_ST_DUMMY: begin
                if (phase_done) begin
                    state_next = SFRC_ST_DATA;
                end
            end
            SFRC_ST_PARAM: begin
                if (phase_done) begin
                    state_next = SFRC_ST_IGNORE;
                end
            end
            default: begin
                state_next = state_reg;
            end
        endcase
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            state_reg <= SFRC_ST_OPCODE;
        end else if (cs_b) begin
            state_reg <= start_state;
        end else if (sclk_rise) begin
            state_reg <= state_next;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            cmd_reg <= '0;
        end else if (cs_b) begin
            cmd_reg <= start_cmd;
        end else if (sclk_rise && state_reg == SFRC_ST_OPCODE && phase_done) begin
            cmd_reg <= cmd_dec;
        end
    end

    // ************************************************************
    // Mode and parameter state
    // ************************************************************
    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            cont_reg <= SFRC_CONT_RST;
        end else if (sclk_rise && state_reg == SFRC_ST_MODE && phase_done) begin
            cont_reg <= in_full[SFRC_CONT_LSB +: 2] == SFRC_CONT_KEY;
        end else if (sclk_rise && state_reg == SFRC_ST_OPCODE && phase_done
                     && in_full[7:0] == SFRC_OP_MODE_RESET) begin
            cont_reg <= SFRC_CONT_RST;
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            read_param_reg <= SFRC_PARAM_RST;
        end else if (sclk_rise && state_reg == SFRC_ST_PARAM && phase_done) begin
            read_param_reg <= in_full[SFRC_PARAM_LSB +: 2];
        end
    end

    // ************************************************************
    // Read address counter and array
    // ************************************************************
    assign addr_max = '1;
    assign byte_fetch = sclk_fall && state_reg == SFRC_ST_DATA && out_cnt_reg == 3'h0;

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B) begin
            addr_reg <= '0;
        end else if (sclk_rise && state_reg == SFRC_ST_ADDR && phase_done) begin
            addr_reg <= in_full[ADDR_W-1:0];
        end else if (byte_fetch) begin
            if (addr_reg == addr_max) begin
                addr_reg <= '0;
            end else begin
                addr_reg <= addr_reg + 1'b1;
            end
        end
    end

    sfrc_array_mem #(
        .ADDR_W(ADDR_W),
        .DATA_W(8)
    ) u_array (
        .i_clk(I_CLOCK),
        .i_wr_en(I_LOAD_EN),
        .i_wr_addr(I_LOAD_ADDR),
        .i_wr_data(I_LOAD_DATA),
        .i_rd_addr(addr_reg),
        .o_rd_data(mem_rdata)
    );

    // ************************************************************
    // Data output shifter
    // ************************************************************
    assign byte_src = (out_cnt_reg == 3'h0) ? mem_rdata : out_sh_reg;

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B || cs_b) begin
            out_cnt_reg <= 3'h0;
            out_sh_reg <= 8'h00;
            io1_out_reg <= 1'b0;
            io0_out_reg <= 1'b0;
        end else if (sclk_fall && state_reg == SFRC_ST_DATA) begin
            io1_out_reg <= byte_src[7];
            if (cmd_reg.dual_data) begin
                io0_out_reg <= byte_src[6];
                out_sh_reg <= {byte_src[5:0], 2'b00};
                out_cnt_reg <= out_cnt_reg + 3'h2;
            end else begin
                io0_out_reg <= 1'b0;
                out_sh_reg <= {byte_src[6:0], 1'b0};
                out_cnt_reg <= out_cnt_reg + 3'h1;
            end
        end
    end

    always_ff @(posedge I_CLOCK) begin
        if (!I_RST_B || cs_b) begin
            drive_reg <= 1'b0;
        end else if (sclk_fall && state_reg == SFRC_ST_DATA) begin
            drive_reg <= 1'b1;
        end
    end

    assign O_IO_LINE_1 = io1_out_reg;
    assign O_IO_LINE_0 = io0_out_reg;
    assign O_IO_LINE_1_OE = drive_reg;
    assign O_IO_LINE_0_OE = drive_reg & cmd_reg.dual_data;
    assign O_CONTINUOUS_MODE = cont_reg;
    assign O_READ_PARAM = read_param_reg;

endmodule

// ==== verif/sfrc_read_engine_checker.sv ====
// Pin-level assertions for the serial flash read command engine
`timescale 1ns/1ps
module sfrc_read_engine_checker
    import sfrc_pkg::*;
#(
    parameter int ADDR_W = 19
) (
    input wire logic I_CLOCK,
    input wire logic I_RST_B,
    input wire logic I_CS_B,
    input wire logic I_SCLK,
    input wire logic I_WRITE_BUSY,
    input wire logic O_IO_LINE_0,
    input wire logic O_IO_LINE_0_OE,
    input wire logic O_IO_LINE_1,
    input wire logic O_IO_LINE_1_OE,
    input wire logic O_CONTINUOUS_MODE,
    input wire logic [1:0] O_READ_PARAM
);
    default clocking cb @(posedge I_CLOCK);
    endclocking
    default disable iff (!I_RST_B);

    oe_release_a: assert property (I_CS_B [*6] |-> !O_IO_LINE_1_OE && !O_IO_LINE_0_OE)
        else $error("io lines still driven after deselect");
    oe_end_a: assert property ($fell(O_IO_LINE_1_OE) |-> $past(I_CS_B, 2))
        else $error("io line 1 released while selected");
    dual_line0_a: assert property (O_IO_LINE_0_OE |-> O_IO_LINE_1_OE)
        else $error("io line 0 driven outside a two-bit data phase");
    data_hold_a: assert property (I_SCLK [*4] ##0 (O_IO_LINE_1_OE && $past(O_IO_LINE_1_OE))
        |-> $stable(O_IO_LINE_1) && $stable(O_IO_LINE_0))
        else $error("data changed while serial clock high");
    oe_start_a: assert property ($rose(O_IO_LINE_1_OE) |-> !I_SCLK && !$past(I_CS_B, 3))
        else $error("output enable rose off a falling clock");
    busy_dual_a: assert property (I_WRITE_BUSY [*8] |-> !O_IO_LINE_0_OE)
        else $error("two-bit read served during write cycle");
    param_hold_a: assert property (!$stable(O_READ_PARAM) |-> !$past(I_CS_B, 3))
        else $error("read parameter changed while deselected");
    cont_hold_a: assert property ($changed(O_CONTINUOUS_MODE) |-> !$past(I_CS_B, 3) && !I_CS_B)
        else $error("continuous mode changed while deselected");
endmodule

bind sfrc_read_engine sfrc_read_engine_checker #(.ADDR_W(ADDR_W)) i_sfrc_read_engine_checker (
    .I_CLOCK(I_CLOCK), .I_RST_B(I_RST_B), .I_CS_B(I_CS_B), .I_SCLK(I_SCLK), .I_WRITE_BUSY(I_WRITE_BUSY),
    .O_IO_LINE_0(O_IO_LINE_0), .O_IO_LINE_0_OE(O_IO_LINE_0_OE), .O_IO_LINE_1(O_IO_LINE_1),
    .O_IO_LINE_1_OE(O_IO_LINE_1_OE), .O_CONTINUOUS_MODE(O_CONTINUOUS_MODE), .O_READ_PARAM(O_READ_PARAM)
);

// ==== verif/sfrc_host_model.sv ====
// Serial host model driving chip select, serial clock and both io lines
`timescale 1ns/1ps
module sfrc_host_model (
    input wire logic i_clk,
    input wire logic i_io_line_0,
    input wire logic i_io_line_1,
    output logic o_cs_b,
    output logic o_sclk,
    output logic o_io_line_0,
    output logic o_io_line_1
);
    logic [1:0] drv_reg;
    logic [1:0] bits_reg;
    logic tog_reg;

    initial begin
        o_cs_b = 1'b1;
        o_sclk = 1'b0;
        drv_reg = 2'b00;
        bits_reg = 2'b00;
        tog_reg = 1'b0;
    end

    // Released lines show a changing pattern, never the last value
    always @(posedge i_clk) begin
        tog_reg <= ~tog_reg;
    end
    assign o_io_line_0 = drv_reg[0] ? bits_reg[0] : tog_reg;
    assign o_io_line_1 = drv_reg[1] ? bits_reg[1] : ~tog_reg;

    task automatic pulse(input logic [1:0] drv, input logic [1:0] bits, output logic [1:0] seen);
        drv_reg <= drv;
        bits_reg <= bits;
        repeat (6) @(posedge i_clk);
        seen = {i_io_line_1, i_io_line_0};
        o_sclk <= 1'b1;
        repeat (5) @(posedge i_clk);
        o_sclk <= 1'b0;
    endtask

    task automatic start();
        @(posedge i_clk);
        o_cs_b <= 1'b0;
        repeat (4) @(posedge i_clk);
    endtask

    task automatic stop();
        drv_reg <= 2'b00;
        repeat (2) @(posedge i_clk);
        o_cs_b <= 1'b1;
        repeat (8) @(posedge i_clk);
    endtask

    task automatic send(input logic [7:0] v, input bit dual);
        logic [1:0] s;
        for (int i = 7; i >= 0; i--) begin
            if (dual && i % 2 == 1) pulse(2'b11, v[i-:2], s);
            else if (!dual) pulse(2'b01, {1'b0, v[i]}, s);
        end
    endtask

    task automatic dummy(input int n);
        logic [1:0] s;
        for (int i = 0; i < n; i++) pulse(2'b11, 2'b00, s);
    endtask

    task automatic recv(input bit dual, output logic [7:0] v);
        logic [1:0] s;
        for (int i = 7; i >= 0; i--) begin
            if (dual && i % 2 == 1) begin
                pulse(2'b00, 2'b00, s);
                v[i-:2] = s;
            end else if (!dual) begin
                pulse(2'b00, 2'b00, s);
                v[i] = s[1];
            end
        end
    endtask
endmodule

// ==== verif/testbench.sv ====
// Self-checking bench for the serial flash read command engine
`timescale 1ns/1ps
module testbench;
    import sfrc_pkg::*;
    localparam int ADDR_W = 8;
    logic clk = 1'b0;
    logic rst_b, busy, four_line, dc_sel, load_en;
    logic [7:0] load_addr, load_data;
    logic cs_b, sclk, host_io0, host_io1, dev_io0, dev_oe0, dev_io1, dev_oe1, cont;
    logic [1:0] param;
    logic line0, line1;
    int miscompares, tests_run;

    always #20 clk = ~clk;
    assign line0 = dev_oe0 ? dev_io0 : host_io0;
    assign line1 = dev_oe1 ? dev_io1 : host_io1;

    sfrc_read_engine #(.ADDR_W(ADDR_W)) i_sfrc_read_engine (
        .I_CLOCK(clk), .I_RST_B(rst_b), .I_CS_B(cs_b), .I_SCLK(sclk), .I_IO_LINE_0(line0),
        .I_IO_LINE_1(line1), .I_WRITE_BUSY(busy), .I_FOUR_LINE_MODE(four_line), .I_DUMMY_CYCLE_SELECT(dc_sel),
        .I_LOAD_EN(load_en), .I_LOAD_ADDR(load_addr), .I_LOAD_DATA(load_data), .O_IO_LINE_0(dev_io0),
        .O_IO_LINE_0_OE(dev_oe0), .O_IO_LINE_1(dev_io1), .O_IO_LINE_1_OE(dev_oe1),
        .O_CONTINUOUS_MODE(cont), .O_READ_PARAM(param)
    );
    sfrc_host_model i_sfrc_host_model (
        .i_clk(clk), .i_io_line_0(line0), .i_io_line_1(line1), .o_cs_b(cs_b), .o_sclk(sclk),
        .o_io_line_0(host_io0), .o_io_line_1(host_io1)
    );

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic stop_test();
        $display("Checks %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // ************************************************************
    // One read: op[8] and mode[8] flag the phases that are sent
    // ************************************************************
    task automatic cmd(input logic [8:0] op, input logic [23:0] addr, input logic [8:0] mode, input int dum,
                       input bit dd, input int n, input logic oe);
        logic [7:0] v;
        i_sfrc_host_model.start();
        if (op[8]) i_sfrc_host_model.send(op[7:0], 1'b0);
        for (int i = 2; i >= 0; i--) i_sfrc_host_model.send(addr[8*i+:8], mode[8]);
        if (mode[8]) i_sfrc_host_model.send(mode[7:0], 1'b1);
        i_sfrc_host_model.dummy(dum);
        for (int k = 0; k < n; k++) begin
            i_sfrc_host_model.recv(dd, v);
            if (oe) check("data", v, 8'(addr + 24'(k)) ^ 8'hA5);
        end
        check("drive", {7'h00, dev_oe1}, {7'h00, oe});
        check("drive line 0", {7'h00, dev_oe0}, {7'h00, oe & dd});
        i_sfrc_host_model.stop();
        check("release", {7'h00, dev_oe1}, 8'h00);
        check("release line 0", {7'h00, dev_oe0}, 8'h00);
    endtask

    task automatic t_read();
        cmd({1'b1, SFRC_OP_READ}, 24'h0000FE, 9'h000, 0, 1'b0, 3, 1'b1);
        $display("t_read done");
    endtask

    task automatic t_fast();
        int dum [4] = '{4, 4, 6, 8};
        cmd({1'b1, SFRC_OP_FAST_READ}, 24'h000010, 9'h000, 8, 1'b0, 2, 1'b1);
        four_line <= 1'b1;
        for (int p = 3; p >= 0; p--) begin
            i_sfrc_host_model.start();
            i_sfrc_host_model.send(SFRC_OP_SET_READ_PARAM, 1'b0);
            i_sfrc_host_model.send({2'b00, p[1:0], 4'h0}, 1'b0);
            i_sfrc_host_model.stop();
            check("param", {6'h00, param}, {6'h00, p[1:0]});
            cmd({1'b1, SFRC_OP_FAST_READ}, {22'h000008, p[1:0]}, 9'h000, dum[p], 1'b0, 1, 1'b1);
        end
        four_line <= 1'b0;
        $display("t_fast done");
    endtask

    task automatic t_dual();
        cmd({1'b1, SFRC_OP_DUAL_OUTPUT_READ}, 24'h000031, 9'h000, 8, 1'b1, 2, 1'b1);
        for (int dc = 0; dc < 2; dc++) begin
            dc_sel <= dc[0];
            cmd({1'b1, SFRC_OP_DUAL_IO_READ}, {23'h000020, dc[0]}, 9'h100, dc ? 8 : 4,
                1'b1, 2, 1'b1);
            check("cont", {7'h00, cont}, 8'h00);
        end
        dc_sel <= 1'b0;
        cmd({1'b1, SFRC_OP_DUAL_IO_READ}, 24'h00007F, 9'h120, 4, 1'b1, 2, 1'b1);
        check("cont", {7'h00, cont}, 8'h01);
        cmd(9'h000, 24'h0000FF, 9'h1FF, 4, 1'b1, 2, 1'b1);
        check("cont", {7'h00, cont}, 8'h00);
        cmd({1'b1, SFRC_OP_DUAL_IO_READ}, 24'h000055, 9'h130, 4, 1'b1, 1, 1'b1);
        check("cont", {7'h00, cont}, 8'h00);
        $display("t_dual done");
    endtask

    task automatic t_busy();
        busy <= 1'b1;
        cmd({1'b1, SFRC_OP_FAST_READ}, 24'h000010, 9'h000, 8, 1'b0, 1, 1'b0);
        cmd({1'b1, SFRC_OP_DUAL_OUTPUT_READ}, 24'h000010, 9'h000, 8, 1'b1, 1, 1'b0);
        cmd({1'b1, SFRC_OP_DUAL_IO_READ}, 24'h000010, 9'h120, 4, 1'b1, 1, 1'b0);
        check("cont", {7'h00, cont}, 8'h00);
        cmd({1'b1, SFRC_OP_READ}, 24'h000012, 9'h000, 0, 1'b0, 1, 1'b1);
        busy <= 1'b0;
        $display("t_busy done");
    endtask

    task automatic t_abort();
        i_sfrc_host_model.start();
        i_sfrc_host_model.send(SFRC_OP_FAST_READ, 1'b0);
        i_sfrc_host_model.send(8'h12, 1'b0);
        i_sfrc_host_model.stop();
        check("release", {7'h00, dev_oe1}, 8'h00);
        cmd({1'b1, SFRC_OP_DUAL_IO_READ}, 24'h000060, 9'h120, 4, 1'b1, 1, 1'b1);
        i_sfrc_host_model.start();
        i_sfrc_host_model.send(8'h00, 1'b1);
        i_sfrc_host_model.stop();
        check("cont", {7'h00, cont}, 8'h01);
        cmd(9'h000, 24'h000066, 9'h100, 4, 1'b1, 1, 1'b1);
        check("cont", {7'h00, cont}, 8'h00);
        cmd({1'b1, SFRC_OP_READ}, 24'h000070, 9'h000, 0, 1'b0, 2, 1'b1);
        $display("t_abort done");
    endtask

    initial begin
        rst_b = 1'b0;
        busy = 1'b0;
        four_line = 1'b0;
        dc_sel = 1'b0;
        load_en = 1'b0;
        load_addr = 8'h00;
        load_data = 8'h00;
        miscompares = 0;
        tests_run = 0;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        for (int a = 0; a < 256; a++) begin
            load_en <= 1'b1;
            load_addr <= 8'(a);
            load_data <= 8'(a) ^ 8'hA5;
            @(posedge clk);
        end
        load_en <= 1'b0;
        repeat (4) @(posedge clk);
        t_read();
        t_fast();
        t_dual();
        t_busy();
        t_abort();
        stop_test();
    end

    initial begin
        repeat (80000) @(posedge clk);
        miscompares++;
        stop_test();
    end
endmodule
